// ---- rtl/sleep_state_power_sequencer.sv ----
// top of the sleep state power sequencer: state machine and supply control
`timescale 1ns/1ps
`include "sleep_seq_consts.svh"

module sleep_state_power_sequencer
  import sleep_seq_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC,
  parameter int unsigned DEB_CYC   = `DEBOUNCE_CYC
) (
  input  wire logic       sys_clk,         // 250 MHz standby clock
  input  wire logic       rst_n,           // sync reset on standby power
  input  wire logic       pwrBtn_n,        // button pin, low pressed
  input  wire wake_src_t  wakeSrc,         // pin-level wake activity
  input  wire logic       lan_wake_enable, // LAN resume setting
  input  wire logic       supplyCtlPresent,// supply has on/off control input
  input  wire logic       swSleepReq,      // software sleep request pulse
  input  wire logic       swSleepS4,       // request target: 1 S4, 0 S1
  input  wire logic       swOffReq,        // software shutdown request pulse
  output logic            supply_on_n,     // supply on, active low
  output pwr_state_t      pwrState,        // current power state
  output domain_en_t      domainEn         // per-domain run enables
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] wakeS1_q, wakeS2_q, wakePrev_q, wakeS1_d, wakeS2_d;
  logic       ctlS1_q, ctlS2_q, ctlS1_d, ctlS2_d;
  logic       pressed, shortPress, longPress;

  always_comb begin
    wakeS1_d = wakeSrc;
    wakeS2_d = wakeS1_q;
    ctlS1_d  = supplyCtlPresent;
    ctlS2_d  = ctlS1_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeS1_q   <= 4'h0;
      wakeS2_q   <= 4'h0;
      wakePrev_q <= 4'h0;
      // assume control fitted until the pin says otherwise: reset alone never powers up
      ctlS1_q    <= 1'b1;
      ctlS2_q    <= 1'b1;
    end else begin
      wakeS1_q   <= wakeS1_d;
      wakeS2_q   <= wakeS2_d;
      wakePrev_q <= wakeS2_q;
      ctlS1_q    <= ctlS1_d;
      ctlS2_q    <= ctlS2_d;
    end
  end

  // ----------------------------------------------------------------
  // button path
  // ----------------------------------------------------------------
  btn_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .btnRaw_n (pwrBtn_n),
    .pressed  (pressed)
  );

  press_timer #(.SHORT_CYC(SHORT_CYC)) u_tmr (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pressed    (pressed),
    .shortPress (shortPress),
    .longPress  (longPress)
  );

  // ----------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------
  function automatic logic anyWake(input logic [3:0] now, input logic [3:0] prev,
                                   input logic lanEn);
    logic [3:0] rise;
    rise = now & ~prev;
    // lan bits are the top two of the packed struct
    anyWake = (lanEn && (rise[3] || rise[2]))
            || rise[1]
            || rise[0];
  endfunction : anyWake

  logic wakeEvt;
  assign wakeEvt = anyWake(wakeS2_q, wakePrev_q, lan_wake_enable);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  pwr_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWR_S0: begin
        if (longPress || swOffReq) begin
          state_d = PWR_S5;
        end else if (swSleepReq && ctlS2_q) begin
          // sleep only from S0 on software request
          state_d = swSleepS4 ? PWR_S4 : PWR_S1;
        end
      end
      PWR_S1, PWR_S4: begin
        if (longPress) begin
          state_d = PWR_S5;
        end else if (shortPress || wakeEvt) begin
          state_d = PWR_S0;
        end
      end
      PWR_S5: begin
        if (shortPress || wakeEvt) begin
          state_d = PWR_S0;
        end
      end
    endcase
    // no supply control: board simply runs while powered
    if (!ctlS2_q) begin
      state_d = PWR_S0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PWR_S5;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, registered
  // ----------------------------------------------------------------
  logic       supplyOn_nq, supplyOn_nd;
  domain_en_t dom_q, dom_d;

  always_comb begin
    // S1 keeps rails up for memory; S4/S5 drop the main supply
    supplyOn_nd = !(state_q == PWR_S0 || state_q == PWR_S1);
    dom_d.rtcRun    = 1'b1;
    dom_d.ledOn     = 1'b1;
    dom_d.cpuRun    = (state_q == PWR_S0);
    dom_d.driveRun  = (state_q == PWR_S0);
    dom_d.memRetain = (state_q == PWR_S0) || (state_q == PWR_S1);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      supplyOn_nq <= 1'b1;
      dom_q       <= 5'b00011;
    end else begin
      supplyOn_nq <= supplyOn_nd;
      dom_q       <= dom_d;
    end
  end

  assign supply_on_n = supplyOn_nq;
  assign pwrState    = state_q;
  assign domainEn    = dom_q;
endmodule : sleep_state_power_sequencer

// ---- shared/sleep_seq_consts.svh ----
// constants for the sleep state power sequencer
`ifndef SLEEP_SEQ_CONSTS_SVH
`define SLEEP_SEQ_CONSTS_SVH
`define CLK_FREQ_HZ        250000000
`define SHORT_PRESS_MS     4000
`define LONG_PRESS_MAX_MS  6000
`define DEBOUNCE_US        10
`define SHORT_PRESS_CYC    ((`CLK_FREQ_HZ / 1000) * `SHORT_PRESS_MS)
`define LONG_PRESS_MAX_CYC ((`CLK_FREQ_HZ / 1000) * `LONG_PRESS_MAX_MS)
`define DEBOUNCE_CYC       ((`CLK_FREQ_HZ / 1000000) * `DEBOUNCE_US)
`define PRESS_CNT_W        32
`define LAN_PORTS          2
`endif

// ---- shared/sleep_seq_pkg.sv ----
// types for the sleep state power sequencer
package sleep_seq_pkg;
  typedef enum logic [1:0] {
    PWR_S0,
    PWR_S1,
    PWR_S4,
    PWR_S5
  } pwr_state_t;

  typedef struct packed {
    logic [1:0] lanEvent;
    logic       ps2Activity;
    logic       usbActivity;
  } wake_src_t;

  typedef struct packed {
    logic cpuRun;
    logic driveRun;
    logic memRetain;
    logic rtcRun;
    logic ledOn;
  } domain_en_t;
endpackage : sleep_seq_pkg

// ---- rtl/btn_debounce.sv ----
// two-flop synchroniser and debounce filter for the power button
`timescale 1ns/1ps
module btn_debounce
  import sleep_seq_pkg::*;
#(
  parameter int unsigned DEB_CYC = 2500
) (
  input  wire logic sys_clk,   // standby clock
  input  wire logic rst_n,     // sync reset
  input  wire logic btnRaw_n,  // button pin, low pressed
  output logic      pressed    // debounced, high pressed
);
  logic sync1_q, sync1_d, sync2_q, sync2_d, pressed_q, pressed_d;
  logic [31:0] cnt_q, cnt_d;

  always_comb begin
    sync1_d   = btnRaw_n;
    sync2_d   = sync1_q;
    pressed_d = pressed_q;
    cnt_d     = 32'h0000_0000;
    if ((~sync2_q) != pressed_q) begin
      if (cnt_q >= DEB_CYC - 1) begin
        pressed_d = ~sync2_q;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q   <= 1'b1;
      sync2_q   <= 1'b1;
      pressed_q <= 1'b0;
      cnt_q     <= 32'h0000_0000;
    end else begin
      sync1_q   <= sync1_d;
      sync2_q   <= sync2_d;
      pressed_q <= pressed_d;
      cnt_q     <= cnt_d;
    end
  end

  assign pressed = pressed_q;
endmodule : btn_debounce

// ---- rtl/press_timer.sv ----
// measures a debounced press and classifies it on release or at the long mark
`timescale 1ns/1ps
module press_timer #(
  parameter int unsigned SHORT_CYC = 1000000000
) (
  input  wire logic sys_clk,    // standby clock
  input  wire logic rst_n,      // sync reset
  input  wire logic pressed,    // debounced press level
  output logic      shortPress, // pulse: released before short mark
  output logic      longPress   // pulse: held to the short mark
);
  logic [31:0] cnt_q, cnt_d;
  logic        fired_q, fired_d, prev_q, shortP_q, shortP_d, longP_q, longP_d;

  always_comb begin
    cnt_d    = cnt_q;
    fired_d  = fired_q;
    shortP_d = 1'b0;
    longP_d  = 1'b0;
    if (pressed) begin
      if (!prev_q) begin
        cnt_d   = 32'h0000_0000;
        fired_d = 1'b0;
      end else if (!fired_q) begin
        cnt_d = cnt_q + 32'h0000_0001;
        // long mark reached while still held: act now, 4 s in the 4-6 s window
        if (cnt_q >= SHORT_CYC - 1) begin
          longP_d = 1'b1;
          fired_d = 1'b1;
        end
      end
    end else if (prev_q && !fired_q) begin
      shortP_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q    <= 32'h0000_0000;
      fired_q  <= 1'b0;
      prev_q   <= 1'b0;
      shortP_q <= 1'b0;
      longP_q  <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      fired_q  <= fired_d;
      prev_q   <= pressed;
      shortP_q <= shortP_d;
      longP_q  <= longP_d;
    end
  end

  assign shortPress = shortP_q;
  assign longPress  = longP_q;
endmodule : press_timer

// ---- bench/atx_partner.sv ----
// button and supply stand-in facing the sequencer
`timescale 1ns/1ps
module atx_partner (
  input  wire logic sys_clk,     // standby clock
  input  wire logic supply_on_n, // supply request, low on
  output logic      pwrBtn_n,    // button, pulled up when open
  output logic      railOn       // main rails up
);
  initial pwrBtn_n = 1'b1;
  initial railOn = 1'b0;
  always @(posedge sys_clk) railOn <= !supply_on_n;
  task automatic hold(input int n);
    @(posedge sys_clk) pwrBtn_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    pwrBtn_n <= 1'b1;
  endtask : hold
endmodule : atx_partner

// ---- bench/sleep_seq_sva.sv ----
// assertion checker for the sleep state power sequencer
`timescale 1ns/1ps
module sleep_seq_sva
  import sleep_seq_pkg::*;
(
  input wire logic       sys_clk,          // clock
  input wire logic       rst_n,            // sync reset
  input wire logic       supplyCtlPresent, // supply control fitted
  input wire logic       swSleepReq,       // sleep request
  input wire logic       supply_on_n,      // supply on, low
  input wire pwr_state_t pwrState,         // state
  input wire domain_en_t domainEn          // domain enables
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_supOn; pwrState inside {PWR_S0, PWR_S1} |=> !supply_on_n; endproperty
  a_supOn: assert property (p_supOn) else $error("supply off while on");
  property p_supOff; pwrState inside {PWR_S4, PWR_S5} |=> supply_on_n; endproperty
  a_supOff: assert property (p_supOff) else $error("supply on while off");
  property p_s1Dom; pwrState == PWR_S1 |=> domainEn == 5'h07; endproperty
  a_s1Dom: assert property (p_s1Dom) else $error("standby domains");
  property p_s4Dom; pwrState == PWR_S4 |=> domainEn == 5'h03; endproperty
  a_s4Dom: assert property (p_s4Dom) else $error("hibernate domains");
  property p_s5Dom; pwrState == PWR_S5 |=> domainEn == 5'h03; endproperty
  a_s5Dom: assert property (p_s5Dom) else $error("soft-off domains");
  property p_fromS0;
    $changed(pwrState) && pwrState inside {PWR_S1, PWR_S4}
      |-> $past(pwrState) == PWR_S0 && $past(swSleepReq);
  endproperty
  a_fromS0: assert property (p_fromS0) else $error("sleep entry");
  property p_noCtl; !supplyCtlPresent [*3] |=> pwrState == PWR_S0; endproperty
  a_noCtl: assert property (p_noCtl) else $error("sleep without control");
  property p_wake;
    $past(pwrState) != PWR_S0 && $changed(pwrState) |-> pwrState inside {PWR_S0, PWR_S5};
  endproperty
  a_wake: assert property (p_wake) else $error("bad exit");
endmodule : sleep_seq_sva
bind sleep_state_power_sequencer sleep_seq_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .supplyCtlPresent(supplyCtlPresent), .swSleepReq(swSleepReq),
  .supply_on_n(supply_on_n), .pwrState(pwrState), .domainEn(domainEn));

// ---- bench/test_sleep_state_power_sequencer.sv ----
// self-checking bench for the sleep state power sequencer
`timescale 1ns/1ps
module test_sleep_state_power_sequencer;
  import sleep_seq_pkg::*;
  logic sys_clk = 0, rst_n = 0, lanEn = 1, ctl = 1, req = 0, toS4 = 0, off = 0;
  logic supN, btnN, railOn;
  wake_src_t  wake = '0;
  pwr_state_t st;
  domain_en_t dom;
  int errors = 0, n_compared = 0, seed = 97, r;
  always #2 sys_clk = ~sys_clk;
  // short counts keep the run brief
  sleep_state_power_sequencer #(.SHORT_CYC(100), .DEB_CYC(4)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .pwrBtn_n(btnN), .wakeSrc(wake), .lan_wake_enable(lanEn),
    .supplyCtlPresent(ctl), .swSleepReq(req), .swSleepS4(toS4), .swOffReq(off),
    .supply_on_n(supN), .pwrState(st), .domainEn(dom));
  atx_partner u_atx (.sys_clk(sys_clk), .supply_on_n(supN), .pwrBtn_n(btnN), .railOn(railOn));
  function automatic domain_en_t domFor(pwr_state_t s);
    if (s == PWR_S0) return 5'h1f;
    if (s == PWR_S1) return 5'h07;
    return 5'h03;
  endfunction : domFor
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : fail
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // bounded wait for a state, then its supply and domains once settled
  task automatic waitSt(input pwr_state_t e, input int n);
    #1;
    while (st !== e && n > 0) begin
      @(posedge sys_clk);
      #1;
      n--;
    end
    n_compared++;
    if (st !== e) fail("state");
    repeat (2) @(posedge sys_clk);
    #1;
    n_compared++;
    if (dom !== domFor(e) || supN !== (e inside {PWR_S4, PWR_S5})
        || railOn !== !(e inside {PWR_S4, PWR_S5})) fail("outputs");
  endtask : waitSt
  task automatic sleep(input logic s4);
    @(posedge sys_clk);
    req <= 1'b1;
    toS4 <= s4;
    @(posedge sys_clk);
    req <= 1'b0;
  endtask : sleep
  task automatic wakeBy(input int b);
    @(posedge sys_clk);
    wake <= 4'h1 << b;
    repeat (3) @(posedge sys_clk);
    wake <= '0;
  endtask : wakeBy
  initial begin
    @(posedge sys_clk);
    #1;
    n_compared++;
    if (st !== PWR_S5 || supN !== 1'b1 || dom !== 5'h03) fail("reset");
    @(posedge sys_clk) rst_n <= 1'b1;
    u_atx.hold(20);
    waitSt(PWR_S0, 60);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      sleep(r[0]);
      waitSt(r[0] ? PWR_S4 : PWR_S1, 3);
      sleep(~r[0]);
      waitSt(r[0] ? PWR_S4 : PWR_S1, 0);
      if (i < 4) wakeBy(i);
      else u_atx.hold(10 + r[5:1]);
      waitSt(PWR_S0, 60);
    end
    @(posedge sys_clk) lanEn <= 1'b0;
    sleep(1'b0);
    waitSt(PWR_S1, 3);
    wakeBy(3);
    waitSt(PWR_S1, 0);
    wakeBy(1);
    waitSt(PWR_S0, 20);
    @(posedge sys_clk) lanEn <= 1'b1;
    u_atx.hold(150);
    waitSt(PWR_S5, 5);
    repeat (20) @(posedge sys_clk);
    waitSt(PWR_S5, 0);
    u_atx.hold(20);
    waitSt(PWR_S0, 60);
    // mid-run reset from full-on must land in soft-off and stay there
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    waitSt(PWR_S5, 0);
    u_atx.hold(20);
    waitSt(PWR_S0, 60);
    // software shutdown pulse from full-on
    @(posedge sys_clk) off <= 1'b1;
    @(posedge sys_clk) off <= 1'b0;
    waitSt(PWR_S5, 3);
    u_atx.hold(20);
    waitSt(PWR_S0, 60);
    sleep(1'b1);
    waitSt(PWR_S4, 3);
    u_atx.hold(150);
    waitSt(PWR_S5, 5);
    @(posedge sys_clk) ctl <= 1'b0;
    waitSt(PWR_S0, 5);
    sleep(1'b0);
    waitSt(PWR_S0, 0);
    wrap_up;
  end
  initial begin
    #(4 * 20000);
    errors++;
    wrap_up;
  end
endmodule : test_sleep_state_power_sequencer
